// *** common/gpm_pkg.sv ***
// Types shared by the power-mode and time-base logic
// Assumes the constants header is included by the design file
package gpm_pkg;
  // ==========================================
  // Power states
  typedef enum logic [2:0] {
    GPM_SUSPEND   = 3'b000,
    GPM_NORMAL    = 3'b001,
    GPM_FAST      = 3'b010,
    GPM_WAKE_SUSP = 3'b011,
    GPM_WAKE_FAST = 3'b100
  } gpm_state_t;
  typedef enum logic [1:0] {
    GPM_REQ_SUSPEND = 2'b00,
    GPM_REQ_NORMAL  = 2'b01,
    GPM_REQ_FAST    = 2'b10
  } gpm_mode_t;
  // ==========================================
  // Carriers
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } gpm_rate_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpm_reg_req_t;
endpackage

// *** common/gpm_regs.svh ***
// Register map, field ranges, reset values and timing constants
// Assumes a 10 MHz core clock and a byte-wide register port
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
// ==========================================
// Register offsets
`define GPM_ADDR_ERR   8'h02
`define GPM_ADDR_DATA0 8'h12
`define GPM_ADDR_DATA5 8'h17
`define GPM_ADDR_TIME0 8'h18
`define GPM_ADDR_TIME1 8'h19
`define GPM_ADDR_TIME2 8'h1a
`define GPM_ADDR_FIFO  8'h24
`define GPM_ADDR_FILT  8'h42
`define GPM_ADDR_DOWNS 8'h45
`define GPM_ADDR_SLEEP 8'h6c
// ==========================================
// Fields and reset values
`define GPM_ODR_F      3:0
`define GPM_BWP_F      6:4
`define GPM_DOWNS_F    2:0
`define GPM_SLP_EN     0
`define GPM_SLP_SEL    1
`define GPM_FILT_RST   8'h28
`define GPM_DOWNS_RST  8'h00
`define GPM_SLEEP_RST  8'h00
`define GPM_ODR_MIN    4'h6
`define GPM_ODR_MAX    4'hd
`define GPM_BWP_MAX    3'h2
`define GPM_ODR_BASE   5'h10
`define GPM_RAW_MASK   24'h000003
`define GPM_ERR_NONE   8'h00
`define GPM_ERR_CONF   8'h01
`define GPM_EMPTY_WORD 16'h8000
`define GPM_CLAMP_WORD 16'h8001
`define GPM_REFUSED    8'h00
`define GPM_FRAME_LAST 3'h5
// ==========================================
// Timing
`define GPM_CLK_NS     100
`define GPM_MS_NS      1000000
`define GPM_TICK_NS    39000
`define GPM_TICK_CYC   (`GPM_TICK_NS / `GPM_CLK_NS)
`define GPM_SUSP_MS    50
`define GPM_FAST_MS    10
`endif

// *** hdl/gpm_power_time.sv ***
// Power-mode control, sensor time base, rate filter and sample FIFO
// Assumes raw samples come from logic on core_clk; the wake pin is async
`timescale 1ns/10ps
`include "gpm_regs.svh"
`default_nettype none
module gpm_power_time
#(
  parameter int SUSP_WAKE_CYC = `GPM_SUSP_MS * (`GPM_MS_NS / `GPM_CLK_NS),
  parameter int FAST_WAKE_CYC = `GPM_FAST_MS * (`GPM_MS_NS / `GPM_CLK_NS),
  parameter int FIFO_DEPTH    = 16
)
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // Register port of the serial interface
  input  wire gpm_pkg::gpm_reg_req_t regReq,
  output logic [7:0]                 regRdData,
  output logic                       regRdValid,
  // Power mode request
  input  wire logic                  modeReqValid,
  input  wire gpm_pkg::gpm_mode_t    modeReq,
  input  wire logic                  wakePin,
  // Sensor front end and results
  input  wire gpm_pkg::gpm_rate_t    sensorRaw,
  output gpm_pkg::gpm_state_t        powerState,
  output gpm_pkg::gpm_rate_t         rateData,
  output logic                       dataUpdate
);
  import gpm_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [8:0] TICK_LAST = 9'(`GPM_TICK_CYC - 1);
  // ==========================================
  // Time base
  logic [8:0]  tickCnt, next_tickCnt;
  logic [23:0] sensorTime, next_sensorTime;
  logic        tick;
  always_comb
  begin
    tick = (tickCnt == TICK_LAST);
    next_tickCnt = tick ? 9'h000 : tickCnt + 9'h001;
    next_sensorTime = tick ? sensorTime + 24'h1 : sensorTime;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      tickCnt    <= 9'h000;
      sensorTime <= 24'h0;
    end
    else
    begin
      tickCnt    <= next_tickCnt;
      sensorTime <= next_sensorTime;
    end
  end
  // ==========================================
  // Configuration and strobes
  logic [7:0]  filtCfg, downsCfg, sleepCfg, errReg;
  logic [7:0]  next_filtCfg, next_downsCfg, next_sleepCfg, next_errReg;
  logic        cfgOk, rawStrobe, odrStrobe, fifoStrobe;
  logic [4:0]  odrBit, fifoBit, shAmt;
  logic [23:0] odrMask, fifoMask;
  always_comb
  begin
    cfgOk = (filtCfg[`GPM_ODR_F] >= `GPM_ODR_MIN) && (filtCfg[`GPM_ODR_F] <= `GPM_ODR_MAX)
            && (filtCfg[`GPM_BWP_F] <= `GPM_BWP_MAX);
    odrBit = `GPM_ODR_BASE - {1'b0, filtCfg[`GPM_ODR_F]};
    fifoBit = odrBit + {2'b00, downsCfg[`GPM_DOWNS_F]};
    shAmt = odrBit - 5'h02;
    odrMask = (24'h1 << odrBit) - 24'h1;
    fifoMask = (24'h1 << fifoBit) - 24'h1;
    // Strobes land on the tick that carries bit m over, so data and time agree
    rawStrobe = tick && ((sensorTime & `GPM_RAW_MASK) == `GPM_RAW_MASK);
    odrStrobe = tick && cfgOk && ((sensorTime & odrMask) == odrMask);
    fifoStrobe = tick && cfgOk && ((sensorTime & fifoMask) == fifoMask);
    next_filtCfg = (regReq.wr && regReq.addr == `GPM_ADDR_FILT) ? regReq.wdata : filtCfg;
    next_downsCfg = (regReq.wr && regReq.addr == `GPM_ADDR_DOWNS) ? regReq.wdata : downsCfg;
    next_sleepCfg = (regReq.wr && regReq.addr == `GPM_ADDR_SLEEP) ? regReq.wdata : sleepCfg;
    next_errReg = cfgOk ? `GPM_ERR_NONE : `GPM_ERR_CONF;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      filtCfg  <= `GPM_FILT_RST;
      downsCfg <= `GPM_DOWNS_RST;
      sleepCfg <= `GPM_SLEEP_RST;
      errReg   <= `GPM_ERR_NONE;
    end
    else
    begin
      filtCfg  <= next_filtCfg;
      downsCfg <= next_downsCfg;
      sleepCfg <= next_sleepCfg;
      errReg   <= next_errReg;
    end
  end
  // ==========================================
  // Power manager
  logic        wakeMeta, wakeSync, autoSlept, next_autoSlept;
  logic [31:0] wakeCnt, next_wakeCnt;
  gpm_state_t  next_state;
  always_comb
  begin
    next_state = powerState;
    next_autoSlept = autoSlept;
    next_wakeCnt = 32'h0;
    case (powerState)
      GPM_WAKE_SUSP:
      begin
        next_wakeCnt = wakeCnt + 32'h1;
        if (wakeCnt == 32'(SUSP_WAKE_CYC - 1))
          next_state = GPM_NORMAL;
      end
      GPM_WAKE_FAST:
      begin
        next_wakeCnt = wakeCnt + 32'h1;
        if (wakeCnt == 32'(FAST_WAKE_CYC - 1))
          next_state = GPM_NORMAL;
      end
      GPM_NORMAL:
      begin
        // Temporary sleep while the external wake source is quiet
        if (sleepCfg[`GPM_SLP_EN] && !wakeSync)
        begin
          next_state = sleepCfg[`GPM_SLP_SEL] ? GPM_FAST : GPM_SUSPEND;
          next_autoSlept = 1'b1;
        end
      end
      GPM_SUSPEND, GPM_FAST:
      begin
        if (autoSlept && wakeSync)
        begin
          next_state = (powerState == GPM_FAST) ? GPM_WAKE_FAST : GPM_WAKE_SUSP;
          next_autoSlept = 1'b0;
        end
      end
      default:
        next_state = GPM_SUSPEND;
    endcase
    // Explicit requests win over the automatic path; any mode to any mode
    // Code 11 is ignored, so a wake in progress keeps its count
    if (modeReqValid && (modeReq inside {GPM_REQ_SUSPEND, GPM_REQ_NORMAL, GPM_REQ_FAST}))
    begin
      next_autoSlept = 1'b0;
      next_wakeCnt = 32'h0;
      case (modeReq)
        GPM_REQ_SUSPEND: next_state = GPM_SUSPEND;
        GPM_REQ_FAST:    next_state = GPM_FAST;
        GPM_REQ_NORMAL:
        begin
          if (powerState == GPM_SUSPEND)
            next_state = GPM_WAKE_SUSP;
          else if (powerState == GPM_FAST)
            next_state = GPM_WAKE_FAST;
          else
          begin
            next_state = powerState;
            next_wakeCnt = wakeCnt;
          end
        end
        default:         next_state = powerState;
      endcase
    end
  end
  always_ff @(posedge core_clk)
  begin
    wakeMeta <= wakePin;
    wakeSync <= wakeMeta;
    if (sys_rst)
    begin
      powerState <= GPM_SUSPEND;
      autoSlept  <= 1'b0;
      wakeCnt    <= 32'h0;
    end
    else
    begin
      powerState <= next_state;
      autoSlept  <= next_autoSlept;
      wakeCnt    <= next_wakeCnt;
    end
  end
  // ==========================================
  // Filter, FIFO and register reads
  logic signed [23:0] acc [3];
  logic signed [23:0] next_acc [3];
  logic signed [23:0] total;
  gpm_rate_t   next_rate, fifoMem [FIFO_DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [2:0]  byteIdx, next_byteIdx;
  logic        isNormal, fifoEmpty, fifoFull, push, fifoRd, next_update;
  logic [15:0] word;
  logic [7:0]  rdByte;
  gpm_rate_t   head;
  always_comb
  begin
    isNormal = (powerState == GPM_NORMAL);
    next_rate = rateData;
    next_update = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      next_acc[i] = isNormal ? acc[i] : 24'sh0;
      total = acc[i] + {{8{sensorRaw[16*i+15]}}, sensorRaw[16*i +: 16]};
      if (isNormal && rawStrobe)
        next_acc[i] = total;
      if (isNormal && odrStrobe)
      begin
        // Box average over the output period; bandwidth field is not modelled
        next_acc[i] = 24'sh0;
        next_rate[16*i +: 16] = 16'(total >>> shAmt);
        if (16'(total >>> shAmt) == `GPM_EMPTY_WORD)
          next_rate[16*i +: 16] = `GPM_CLAMP_WORD;
        next_update = 1'b1;
      end
    end
    fifoEmpty = (wrPtr == rdPtr);
    fifoFull = (wrPtr[AW-1:0] == rdPtr[AW-1:0]) && (wrPtr[AW] != rdPtr[AW]);
    push = isNormal && fifoStrobe && !fifoFull;
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    // FIFO reads refused in suspend only; burst pacing is the host's job
    fifoRd = regReq.rd && (regReq.addr == `GPM_ADDR_FIFO) && (powerState != GPM_SUSPEND);
    head = fifoMem[rdPtr[AW-1:0]];
    word = fifoEmpty ? `GPM_EMPTY_WORD : head[16*byteIdx[2:1] +: 16];
    next_byteIdx = byteIdx;
    next_rdPtr = rdPtr;
    if (fifoRd)
    begin
      next_byteIdx = (byteIdx == `GPM_FRAME_LAST) ? 3'h0 : byteIdx + 3'h1;
      if (!fifoEmpty && byteIdx == `GPM_FRAME_LAST)
        next_rdPtr = rdPtr + 1'b1;
    end
    case (regReq.addr)
      `GPM_ADDR_ERR:   rdByte = errReg;
      `GPM_ADDR_TIME0: rdByte = sensorTime[7:0];
      `GPM_ADDR_TIME1: rdByte = sensorTime[15:8];
      `GPM_ADDR_TIME2: rdByte = sensorTime[23:16];
      `GPM_ADDR_FIFO:  rdByte = fifoRd ? word[8*byteIdx[0] +: 8] : `GPM_REFUSED;
      `GPM_ADDR_FILT:  rdByte = filtCfg;
      `GPM_ADDR_DOWNS: rdByte = downsCfg;
      `GPM_ADDR_SLEEP: rdByte = sleepCfg;
      default:
      begin
        rdByte = 8'h00;
        if (regReq.addr >= `GPM_ADDR_DATA0 && regReq.addr <= `GPM_ADDR_DATA5)
          rdByte = rateData[8*(regReq.addr-`GPM_ADDR_DATA0) +: 8];
      end
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (push)
      fifoMem[wrPtr[AW-1:0]] <= rateData;
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 3; i++)
        acc[i] <= 24'sh0;
      rateData   <= '0;
      dataUpdate <= 1'b0;
      wrPtr      <= '0;
      rdPtr      <= '0;
      byteIdx    <= 3'h0;
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end
    else
    begin
      acc        <= next_acc;
      rateData   <= next_rate;
      dataUpdate <= next_update;
      wrPtr      <= next_wrPtr;
      rdPtr      <= next_rdPtr;
      byteIdx    <= next_byteIdx;
      regRdData  <= regReq.rd ? rdByte : regRdData;
      regRdValid <= regReq.rd;
    end
  end
  // ==========================================
  // Checks
  time_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    tick |=> sensorTime == $past(sensorTime) + 24'h1) else $error("time step wrong");
  time_sleep_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (powerState != GPM_NORMAL) && !tick |=> $stable(sensorTime)) else $error("time moved");
  raw_rate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rawStrobe |-> tick && sensorTime[1:0] == 2'b11) else $error("raw strobe off grid");
  sync_bit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataUpdate |-> (sensorTime & $past(odrMask)) == 24'h0) else $error("update off grid");
  fast_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerState == GPM_FAST |=> !dataUpdate && $stable(rateData)) else $error("fast sampled");
  clamp_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataUpdate |-> rateData.x != `GPM_EMPTY_WORD && rateData.y != `GPM_EMPTY_WORD
      && rateData.z != `GPM_EMPTY_WORD)
    else $error("empty word as sample");
  susp_refuse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    regReq.rd && regReq.addr == `GPM_ADDR_FIFO && powerState == GPM_SUSPEND
    |=> regRdData == `GPM_REFUSED && $stable(rdPtr)) else $error("suspend readout");
  empty_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    fifoRd && fifoEmpty && byteIdx[0] |=> regRdData == 8'(`GPM_EMPTY_WORD >> 8))
    else $error("empty marker wrong");
  wake_bound_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerState == GPM_WAKE_SUSP |-> wakeCnt < 32'(SUSP_WAKE_CYC)) else $error("wake slow");
  err_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !cfgOk |=> errReg == `GPM_ERR_CONF) else $error("error code missing");
  mode_cfg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    modeReqValid && !regReq.wr |=> $stable(filtCfg)) else $error("mode touched odr");
  reset_susp_a: assert property (@(posedge core_clk)
    $past(sys_rst) && !sys_rst |-> powerState == GPM_SUSPEND) else $error("not suspend");
endmodule
`default_nettype wire

// *** verification/gpm_host_model.sv ***
// Host model driving the register port of the power and time block
// Assumes the port samples strobes on the rising edge of core_clk
`timescale 1ns/10ps
`default_nettype none
module gpm_host_model
#(
  parameter int SLEEP_WR_CYC = 4000
)
(
  // Clock and device state
  input  wire logic                  core_clk,
  input  wire gpm_pkg::gpm_state_t   powerState,
  // Register port
  output gpm_pkg::gpm_reg_req_t      regReq,
  input  wire logic [7:0]            regRdData,
  input  wire logic                  regRdValid
);
  import gpm_pkg::*;
  // ==========================================
  // Access tasks
  initial regReq = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    #1 regReq.wr = 1'b0;
    // Released lines flip so a stale address is never mistaken for a live one
    regReq.addr = ~a;
    regReq.wdata = ~d;
    // Single writes only; sleep modes need a long settle after each
    if (powerState == GPM_SUSPEND || powerState == GPM_FAST)
      repeat (SLEEP_WR_CYC) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n = 0;
    @(posedge core_clk);
    #1 regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    #1 regReq.rd = 1'b0;
    regReq.addr = ~a;
    while (regRdValid !== 1'b1 && n < 4)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the power-mode and time-base block
// Assumes the host model file is compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gpm_pkg::*;
  // ==========================================
  // Signals
  localparam int SUSP_W = 20;
  localparam int FAST_W = 10;
  logic         core_clk;
  logic         sys_rst;
  gpm_reg_req_t regReq;
  logic [7:0]   regRdData;
  logic         regRdValid;
  logic         modeReqValid;
  gpm_mode_t    modeReq;
  logic         wakePin;
  gpm_rate_t    sensorRaw;
  gpm_state_t   powerState;
  gpm_rate_t    rateData;
  logic         dataUpdate;
  int           errCount = 0;
  int           comparisons = 0;
  int           upd = 0;
  int           u0;
  logic [7:0]   b;
  logic [7:0]   t0;
  logic [7:0]   t1;
  logic [7:0]   frame [6] = '{8'h01, 8'h80, 8'h34, 8'h12, 8'hff, 8'h7f};
  gpm_power_time #(.SUSP_WAKE_CYC(SUSP_W), .FAST_WAKE_CYC(FAST_W), .FIFO_DEPTH(4))
    gpm_power_time_inst (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq),
    .regRdData(regRdData), .regRdValid(regRdValid), .modeReqValid(modeReqValid),
    .modeReq(modeReq), .wakePin(wakePin), .sensorRaw(sensorRaw),
    .powerState(powerState), .rateData(rateData), .dataUpdate(dataUpdate));
  gpm_host_model gpm_host_model_inst (.core_clk(core_clk), .powerState(powerState),
    .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (dataUpdate === 1'b1)
      upd <= upd + 1;
  // ==========================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    gpm_host_model_inst.rd(a, b);
    check(16'(regRdValid), 16'h0001);
    check(16'(b), 16'(exp));
  endtask
  task automatic req(input gpm_mode_t m);
    @(posedge core_clk);
    #1 modeReqValid = 1'b1;
    modeReq = m;
    @(posedge core_clk);
    #1 modeReqValid = 1'b0;
  endtask
  task automatic waitst(input gpm_state_t s, input int lim);
    int n = 0;
    while (powerState !== s && n < lim)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check(16'(powerState), 16'(s));
  endtask
  task automatic wake(input gpm_state_t s, input int n);
    req(GPM_REQ_NORMAL);
    check(16'(powerState), 16'(s));
    repeat (n - 1) @(posedge core_clk);
    #1 check(16'(powerState), 16'(s));
    @(posedge core_clk);
    #1 check(16'(powerState), 16'(GPM_NORMAL));
  endtask
  task automatic waitupd(input int k);
    int n = 0;
    while (upd < k && n < 25000)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    check(16'(upd >= k), 16'h0001);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    sys_rst = 1'b1;
    modeReqValid = 1'b0;
    modeReq = GPM_REQ_SUSPEND;
    wakePin = 1'b1;
    sensorRaw = '{z: 16'h7fff, y: 16'h1234, x: 16'h8000};
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    check(16'(powerState), 16'(GPM_SUSPEND));
    rdc(8'h42, 8'h28);
    rdc(8'h45, 8'h00);
    rdc(8'h6c, 8'h00);
    rdc(8'h7f, 8'h00);
    gpm_host_model_inst.rd(8'h18, t0);
    repeat (388) @(posedge core_clk);
    gpm_host_model_inst.rd(8'h18, t1);
    b = t1 - t0;
    check(16'(b), 16'h0001);
    gpm_host_model_inst.wr(8'h42, 8'h25);
    rdc(8'h02, 8'h01);
    gpm_host_model_inst.wr(8'h42, 8'h2d);
    rdc(8'h02, 8'h00);
    check(16'(upd), 16'h0000);
    $display("test reset_config done");
    wake(GPM_WAKE_SUSP, SUSP_W);
    rdc(8'h42, 8'h2d);
    waitupd(6);
    gpm_host_model_inst.rd(8'h18, t0);
    waitupd(7);
    gpm_host_model_inst.rd(8'h18, t1);
    check(16'(t1[2:0]), 16'h0000);
    check(16'(t0[3] ^ t1[3]), 16'h0001);
    check(rateData.x, 16'h8001);
    check(rateData.y, 16'h1234);
    rdc(8'h13, 8'h80);
    $display("test normal_data done");
    req(GPM_REQ_SUSPEND);
    check(16'(powerState), 16'(GPM_SUSPEND));
    rdc(8'h24, 8'h00);
    rdc(8'h24, 8'h00);
    rdc(8'h12, 8'h01);
    req(GPM_REQ_FAST);
    check(16'(powerState), 16'(GPM_FAST));
    u0 = upd;
    for (int f = 0; f < 5; f++)
      for (int i = 0; i < 6; i++)
      begin
        gpm_host_model_inst.rd(8'h24, b);
        if (f >= 2)
          check(16'(b), f == 4 ? ((i % 2) ? 16'h0080 : 16'h0000) : 16'(frame[i]));
      end
    repeat (3500) @(posedge core_clk);
    check(16'(upd), 16'(u0));
    check(rateData.z, 16'h7fff);
    rdc(8'h42, 8'h2d);
    $display("test sleep_fifo done");
    wake(GPM_WAKE_FAST, FAST_W);
    for (int s = 0; s < 2; s++)
    begin
      gpm_host_model_inst.wr(8'h6c, s ? 8'h01 : 8'h03);
      wakePin = 1'b0;
      waitst(s ? GPM_SUSPEND : GPM_FAST, 8);
      wakePin = 1'b1;
      waitst(s ? GPM_WAKE_SUSP : GPM_WAKE_FAST, 8);
      waitst(GPM_NORMAL, 30);
    end
    req(gpm_mode_t'(2'b11));
    check(16'(powerState), 16'(GPM_NORMAL));
    $display("test auto_sleep done");
    summarize();
  end
  initial
  begin
    // Run needs under 40000 cycles; 90000 cycles means a hang
    #(90000 * 100);
    errCount++;
    summarize();
  end
endmodule
`default_nettype wire
